// ==== dv/psid_host.sv ====
// serial host model driving mode 0 frames, msb first
`timescale 1ns/1ns
`default_nettype none
module psid_host (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      csb_n_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    initial begin
        csb_n_o = 1'b1;
        sclk_o  = 1'b0;
        sdi_o   = 1'b0;
    end
    // six clocks per half period leaves margin over the three-clock pin latency
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] v;
        v = {rd, a, (a == 15'h0002) ? (wd & 8'hf3) : wd};
        @(posedge clk_i) csb_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            repeat (6) @(posedge clk_i);
            sclk_o <= 1'b0;
            sdi_o  <= v[i];
            repeat (6) @(posedge clk_i);
            sclk_o <= 1'b1;
            if (i < 8) q[i] = sdo_i;
        end
        repeat (6) @(posedge clk_i);
        sclk_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        csb_n_o <= 1'b1;
        sdi_o   <= ~sdi_o;
        repeat (6) @(posedge clk_i);
    endtask : xfer
endmodule : psid_host
`default_nettype wire

// ==== dv/psid_regs_bench.sv ====
// self-checking bench for the pll status and id registers
`timescale 1ns/1ns
`default_nettype none
`include "psid_cfg.svh"
module psid_regs_bench;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       csb_n, sclk, sdi, sdo, oe, slp;
    logic       lk = 1'b0, rf = 1'b0, fb = 1'b0;
    logic       ce = 1'b1;
    logic [1:0] fld;
    logic [7:0] q, wd;
    int         failures = 0, compares = 0, seed = 32'h9334;
    initial forever #4 clk_i = ~clk_i;
    psid_host host (.clk_i, .sdo_i(sdo), .csb_n_o(csb_n), .sclk_o(sclk), .sdi_o(sdi));
    psid_regs DUT (.clk_i, .rst_i, .ce_i(ce), .spi_csb_n_i(csb_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
        .pll_locked_i(lk), .ref_present_i(rf), .fb_valid_i(fb), .spi_sdo_o(sdo), .spi_sdo_oe_o(oe),
        .sleep_o(slp), .sleep_field_o(fld));
    function automatic logic [7:0] exp_status(input logic [2:0] v, input logic [1:0] s);
        return {v, v[1] & v[0], 2'b00, s};
    endfunction : exp_status
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : cmp8
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            {lk, rf, fb} <= 3'(i);
            repeat (4) @(posedge clk_i);
            host.xfer(1'b1, `PSID_OFS_STATUS, 8'h00, q);
            cmp8("status", exp_status(3'(i), 2'h0), q);
        end
        $display("status levels done");
        for (int i = 0; i < 4; i++) begin
            wd = 8'($random(seed));
            wd[1:0] = {2{i[0]}};
            host.xfer(1'b0, `PSID_OFS_STATUS, wd, q);
            cmp8("sleep", {5'h00, wd[0], wd[1:0]}, {5'h00, slp, fld});
            host.xfer(1'b1, `PSID_OFS_STATUS, 8'h00, q);
            cmp8("status rw", exp_status(3'b111, wd[1:0]), q);
        end
        $display("sleep writes done");
        host.xfer(1'b0, `PSID_OFS_CLASS, 8'($random(seed)), q);
        host.xfer(1'b0, `PSID_OFS_SERIAL_LO, 8'($random(seed)), q);
        host.xfer(1'b1, `PSID_OFS_CLASS, 8'h00, q);
        cmp8("class", {`PSID_RSVD_HI_NIBBLE, `PSID_CLASS_CODE_DEF}, q);
        host.xfer(1'b1, `PSID_OFS_SERIAL_LO, 8'h00, q);
        cmp8("serial", {`PSID_SERIAL_NIB_DEF, `PSID_SERIAL_RSVD_DEF}, q);
        host.xfer(1'b1, 15'h0005, 8'h00, q);
        cmp8("unmapped", `PSID_UNMAPPED_READ, q);
        $display("read-only done");
        host.xfer(1'b0, `PSID_OFS_STATUS, 8'h03, q);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        cmp8("reset sleep", 8'h00, {5'h00, slp, fld});
        host.xfer(1'b1, `PSID_OFS_STATUS, 8'h00, q);
        cmp8("reset status", 8'hf0, q);
        $display("mid-run reset done");
        ce <= 1'b0;
        host.xfer(1'b0, `PSID_OFS_STATUS, 8'h03, q);
        ce <= 1'b1;
        repeat (4) @(posedge clk_i);
        cmp8("frozen sleep", 8'h00, {5'h00, slp, fld});
        $display("clock enable freeze done");
        give_verdict();
    end
endmodule : psid_regs_bench
bind psid_regs psid_regs_properties chk (.clk_i, .rst_i, .ce_i, .spi_csb_n_i, .spi_sclk_i, .spi_sdi_i,
    .pll_locked_i, .ref_present_i, .fb_valid_i, .spi_sdo_o, .spi_sdo_oe_o, .sleep_o, .sleep_field_o);
`default_nettype wire

// ==== dv/psid_regs_properties.sv ====
// port-level checks for the pll status and id register slice
`timescale 1ns/1ns
`default_nettype none
module psid_regs_properties (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic       spi_csb_n_i,
    input wire logic       spi_sclk_i,
    input wire logic       spi_sdi_i,
    input wire logic       pll_locked_i,
    input wire logic       ref_present_i,
    input wire logic       fb_valid_i,
    input wire logic       spi_sdo_o,
    input wire logic       spi_sdo_oe_o,
    input wire logic       sleep_o,
    input wire logic [1:0] sleep_field_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_sleep_decode: assert property (ce_i |=> sleep_o == (sleep_field_o == 2'h3))
        else $error("sleep flag wrong");
    chk_field_frame: assert property ($changed(sleep_field_o) |-> !$past(spi_csb_n_i, 3))
        else $error("sleep field changed outside frame");
    chk_field_codes: assert property (sleep_field_o == 2'h0 || sleep_field_o == 2'h3)
        else $error("sleep field holds unwritten code");
    chk_oe_idle: assert property (spi_csb_n_i [*6] |-> !spi_sdo_oe_o)
        else $error("sdo enabled while deselected");
    chk_sdo_idle: assert property (spi_csb_n_i [*6] |-> !spi_sdo_o)
        else $error("sdo not low while deselected");
    chk_oe_start: assert property ($rose(spi_sdo_oe_o) |-> !spi_sclk_i && !spi_csb_n_i)
        else $error("sdo enable rose at wrong time");
    chk_oe_ends: assert property ($fell(spi_sdo_oe_o) |-> spi_csb_n_i)
        else $error("sdo enable fell inside frame");
    chk_sdo_on_fall: assert property (spi_sdo_oe_o && $past(spi_sdo_oe_o) && $changed(spi_sdo_o) |-> !spi_sclk_i)
        else $error("sdo changed while sclk high");
endmodule : psid_regs_properties
`default_nettype wire

// ==== shared/psid_cfg.svh ====
// offsets, field positions, reset values and fixed codes for the pll status and id registers
`ifndef PSID_CFG_SVH
`define PSID_CFG_SVH

`define PSID_ADDR_W              15
`define PSID_OFS_STATUS          15'h0002
`define PSID_OFS_CLASS           15'h0003
`define PSID_OFS_SERIAL_LO       15'h0004

`define PSID_BIT_LOCKED          7
`define PSID_BIT_REF_PRESENT     6
`define PSID_BIT_FB_VALID        5
`define PSID_BIT_REF_FB_OK       4
`define PSID_SLEEP_MSB           1
`define PSID_SLEEP_LSB           0

`define PSID_SLEEP_RESET         2'h0
`define PSID_SLEEP_NORMAL        2'h0
`define PSID_SLEEP_ON            2'h3
`define PSID_RSVD_STATUS         2'h0
`define PSID_RSVD_HI_NIBBLE      4'h0
`define PSID_UNMAPPED_READ       8'h00

`define PSID_INSTR_BITS          16
`define PSID_DATA_BITS           8
`define PSID_INSTR_LAST          4'hf
`define PSID_DATA_LAST           4'h7

// arbitrary neutral identity defaults
`define PSID_CLASS_CODE_DEF      4'h9
`define PSID_SERIAL_NIB_DEF      4'ha
`define PSID_SERIAL_RSVD_DEF     4'h0

`endif

// ==== shared/psid_pkg.sv ====
// types for the pll status and id register block
package psid_pkg;

    typedef enum logic [1:0] {
        PSID_IDLE,
        PSID_INSTR,
        PSID_DATA
    } psid_phase_e;

    typedef struct packed {
        psid_phase_e  phase;
        logic [3:0]   bit_cnt;
        logic [15:0]  shift;
        logic         rd;
        logic [14:0]  addr;
        logic [7:0]   tx;
        logic         sclk_d;
        logic         sdo;
        logic         sdo_oe;
        logic [1:0]   sleep;
        logic         sleep_on;
    } psid_state_s;

endpackage : psid_pkg

// ==== verilog/psid_regs.sv ====
// serial-port slice holding the pll status, device class and low part serial registers
//
// Contract
// [RULE1] status bit 7 is a read-only live copy of the pll lock detector
// [RULE2] status bit 6 reads 1 while a reference clock is detected; writes ignored
// [RULE3] status bit 5 reads 1 while valid n-divider feedback is detected; read-only
// [RULE4] status bit 4 is the and of reference present and feedback valid
// [RULE5] host writes zeros to status bits 3:2; they reset and read as zero
// [RULE6] sleep field bits 1:0 resets to 00; 11 sleeps; host avoids 01 and 10
// [RULE7] locked, reference and feedback present, normal operation: status reads 0xf0
// [RULE8] class register read-only; low nibble fixed code, high nibble reads zero
// [RULE9] serial low register: bits 7:4 part serial nibble, 3:0 fixed; read-only
`timescale 1ns/1ns
`default_nettype none
`include "psid_cfg.svh"

module psid_regs #(
    parameter logic [3:0] CLASS_CODE  = `PSID_CLASS_CODE_DEF,
    parameter logic [3:0] SERIAL_NIB  = `PSID_SERIAL_NIB_DEF,
    parameter logic [3:0] SERIAL_RSVD = `PSID_SERIAL_RSVD_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic spi_csb_n_i,
    input  wire logic spi_sclk_i,
    input  wire logic spi_sdi_i,
    input  wire logic pll_locked_i,
    input  wire logic ref_present_i,
    input  wire logic fb_valid_i,
    output logic      spi_sdo_o,
    output logic      spi_sdo_oe_o,
    output logic      sleep_o,
    output logic [1:0] sleep_field_o
);

    localparam int              NPIN     = 3;
    localparam int              NDET     = 3;
    // chip select idles high, so reset must not look like a selected bus
    localparam logic [NPIN-1:0] PIN_IDLE = 3'h4;

    // all state past the synchronisers sits in one register stage; every output reads it directly
    psid_pkg::psid_state_s s_r;
    psid_pkg::psid_state_s s_nxt;

    logic [NPIN-1:0]  pin_q;
    logic [NDET-1:0]  det_q;
    logic             csb_n_s;
    logic             sclk_s;
    logic             sdi_s;
    logic             locked_s;
    logic             ref_s;
    logic             fb_s;
    logic             rise;
    logic             fall;
    logic [15:0]      instr;
    logic [7:0]       wbyte;
    logic [14:0]      next_addr;

    // spi pins are oversampled; sclk and sdi share one delay so bits stay aligned
    psid_sync #(
        .W       (NPIN),
        .RST_VAL (PIN_IDLE)
    ) u_pin_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({spi_csb_n_i, spi_sclk_i, spi_sdi_i}),
        .q_o   (pin_q)
    );

    // detector levels come from the analog side, unrelated to clk_i
    psid_sync #(
        .W       (NDET),
        .RST_VAL ('0)
    ) u_det_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({pll_locked_i, ref_present_i, fb_valid_i}),
        .q_o   (det_q)
    );

    assign csb_n_s  = pin_q[2];
    assign sclk_s   = pin_q[1];
    assign sdi_s    = pin_q[0];
    assign locked_s = det_q[2];
    assign ref_s    = det_q[1];
    assign fb_s     = det_q[0];

    // live detector copies, reserved zeros and the stored sleep field
    function automatic logic [7:0] status_byte(
        input logic       lk,
        input logic       rf,
        input logic       fb,
        input logic [1:0] slp
    );
        logic [7:0] v;
        v                                  = `PSID_UNMAPPED_READ;
        v[`PSID_BIT_LOCKED]                = lk;                 // see [RULE1]
        v[`PSID_BIT_REF_PRESENT]           = rf;                 // see [RULE2]
        v[`PSID_BIT_FB_VALID]              = fb;                 // see [RULE3]
        v[`PSID_BIT_REF_FB_OK]             = rf & fb;            // see [RULE4]
        v[3:2]                             = `PSID_RSVD_STATUS;  // see [RULE5]
        v[`PSID_SLEEP_MSB:`PSID_SLEEP_LSB] = slp;                // see [RULE6] [RULE7]
        return v;
    endfunction : status_byte

    // unmapped addresses read as zero, so a stream may walk through them harmlessly
    function automatic logic [7:0] read_reg(
        input logic [14:0] a,
        input logic        lk,
        input logic        rf,
        input logic        fb,
        input logic [1:0]  slp
    );
        logic [7:0] v;
        if (a == `PSID_OFS_STATUS) begin
            v = status_byte(lk, rf, fb, slp);
        end else if (a == `PSID_OFS_CLASS) begin
            v = {`PSID_RSVD_HI_NIBBLE, CLASS_CODE};                  // see [RULE8]
        end else if (a == `PSID_OFS_SERIAL_LO) begin
            v = {SERIAL_NIB, SERIAL_RSVD};                           // see [RULE9]
        end else begin
            v = `PSID_UNMAPPED_READ;
        end
        return v;
    endfunction : read_reg

    // bit counter step shared by the instruction and data phases
    function automatic logic [3:0] bump(
        input logic [3:0] cnt
    );
        return cnt + 4'h1;
    endfunction : bump

    always_comb begin
        s_nxt     = s_r;
        rise      = sclk_s & ~s_r.sclk_d;
        fall      = ~sclk_s & s_r.sclk_d;
        instr     = {s_r.shift[14:0], sdi_s};
        wbyte     = {s_r.shift[6:0], sdi_s};
        next_addr = s_r.addr - 15'h0001;
        if (ce_i) begin
            s_nxt.sclk_d = sclk_s;
            if (csb_n_s) begin
                // deselect aborts any frame; a partial data byte is dropped
                s_nxt.phase   = psid_pkg::PSID_IDLE;
                s_nxt.bit_cnt = 4'h0;
                s_nxt.sdo     = 1'b0;
                s_nxt.sdo_oe  = 1'b0;
            end else begin
                case (s_r.phase)
                    psid_pkg::PSID_IDLE,
                    psid_pkg::PSID_INSTR: begin
                        // a rise in the first selected cycle still counts
                        s_nxt.phase = psid_pkg::PSID_INSTR;
                        if (rise) begin
                            s_nxt.shift   = instr;
                            s_nxt.bit_cnt = bump(s_r.bit_cnt);
                            if (s_r.bit_cnt == `PSID_INSTR_LAST) begin
                                // answer byte is a snapshot taken here, not at each fall
                                s_nxt.rd      = instr[15];
                                s_nxt.addr    = instr[14:0];
                                s_nxt.tx      = read_reg(instr[14:0], locked_s, ref_s, fb_s, s_r.sleep);
                                s_nxt.bit_cnt = 4'h0;
                                s_nxt.phase   = psid_pkg::PSID_DATA;
                            end
                        end
                    end
                    psid_pkg::PSID_DATA: begin
                        if (rise) begin
                            s_nxt.shift   = instr;
                            s_nxt.bit_cnt = bump(s_r.bit_cnt);
                            if (s_r.bit_cnt == `PSID_DATA_LAST) begin
                                // only the sleep field is writable; live and reserved bits drop writes
                                if (!s_r.rd && s_r.addr == `PSID_OFS_STATUS) begin
                                    s_nxt.sleep = wbyte[`PSID_SLEEP_MSB:`PSID_SLEEP_LSB]; // see [RULE6]
                                end
                                // streaming walks downward, one byte per address
                                s_nxt.addr    = next_addr;
                                s_nxt.tx      = read_reg(next_addr, locked_s, ref_s, fb_s, s_nxt.sleep);
                                s_nxt.bit_cnt = 4'h0;
                            end
                        end
                        // mode 0: next bit launched on the fall, host samples on the rise
                        if (fall && s_r.rd) begin
                            s_nxt.sdo    = s_r.tx[7];
                            s_nxt.tx     = {s_r.tx[6:0], 1'b0};
                            s_nxt.sdo_oe = 1'b1;
                        end
                    end
                    default: begin
                        // unused encoding falls back to idle
                        s_nxt.phase = psid_pkg::PSID_IDLE;
                    end
                endcase
            end
            // undefined codes 01 and 10 keep the device running
            s_nxt.sleep_on = (s_nxt.sleep == `PSID_SLEEP_ON); // see [RULE6]
        end
    end

    // asynchronous reset clears everything; the pin idle level comes from the synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // registered outputs: sdo, its enable and both sleep views
    assign spi_sdo_o     = s_r.sdo;
    assign spi_sdo_oe_o  = s_r.sdo_oe;
    assign sleep_o       = s_r.sleep_on;
    assign sleep_field_o = s_r.sleep;

endmodule : psid_regs

`default_nettype wire

// ==== verilog/psid_sync.sv ====
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
`default_nettype none

module psid_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // both stages reset to the idle level of their pins, so no false edge follows reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            q_r    <= RST_VAL;
        end else if (ce_i) begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule : psid_sync

`default_nettype wire
